// *** design/spi_frame_top.sv ***
// serial master with prescaled clock, framing and register slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
module spi_frame_top
    import spi_frame_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial pins
    output logic serial_clock,
    output logic serial_data_out,
    input wire logic serial_data_in,
    input wire logic slave_select_pin_in,
    output logic slave_select_pin_out,
    output logic slave_select_pin_oe
);
    typedef enum logic [3:0] {
        st_idle = 4'b0001,
        st_wait = 4'b0010,
        st_sync = 4'b0100,
        st_shift = 4'b1000
    } state_t;

    state_t state_reg;
    logic [15:0] ctrl_one_reg;
    logic [15:0] ctrl_two_reg;
    logic [7:0] aw_addr_reg;
    logic aw_have_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic w_have_reg;
    logic [7:0] tx_hold_reg;
    logic tx_pend_reg;
    logic [7:0] shift_reg;
    logic [7:0] rx_data_reg;
    logic rx_full_reg;
    logic [3:0] bit_cnt_reg;
    logic sclk_reg;
    logic sync_active_reg;
    logic ss_meta_reg;
    logic ss_sync_reg;
    logic ss_prev_reg;
    logic din_meta_reg;
    logic din_sync_reg;
    logic tick;
    logic wr_fire;
    logic data_write;
    logic load_shift;
    logic framed;
    logic ext_sync;
    logic ext_start;
    logic ss_active_in;
    logic [15:0] wr_lo;

    assign framed = ctrl_two_reg[framed_mode_bit];
    assign ext_sync = framed && ctrl_two_reg[fsd_bit];

    // ****************************************************
    // axi4-lite write channel
    // ****************************************************
    assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
    assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
    assign wr_lo = {w_strb_reg[1] ? w_data_reg[15:8] : 8'h00,
                    w_strb_reg[0] ? w_data_reg[7:0] : 8'h00};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_have_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_have_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= resp_okay;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            case (aw_addr_reg[7:2])
                ctrl_one_offset[7:2], ctrl_two_offset[7:2],
                data_offset[7:2]: s_axi_bresp <= resp_okay;
                default: s_axi_bresp <= resp_slverr;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************************
    // control registers
    // ****************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_one_reg <= ctrl_one_reset;
        end else if (wr_fire && aw_addr_reg[7:2] == ctrl_one_offset[7:2]) begin
            ctrl_one_reg <= wr_lo | (ctrl_one_reg & ~{{8{w_strb_reg[1]}},
                                                     {8{w_strb_reg[0]}}});
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_two_reg <= ctrl_two_reset;
        end else if (wr_fire && aw_addr_reg[7:2] == ctrl_two_offset[7:2]) begin
            // unimplemented bits never store
            ctrl_two_reg <= (wr_lo | (ctrl_two_reg & ~{{8{w_strb_reg[1]}},
                            {8{w_strb_reg[0]}}})) & ctrl_two_mask;
        end
    end

    assign data_write = wr_fire && aw_addr_reg[7:2] == data_offset[7:2]
                        && w_strb_reg[0];

    // ****************************************************
    // axi4-lite read channel
    // ****************************************************
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= resp_okay;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= resp_okay;
            case (s_axi_araddr[7:2])
                ctrl_one_offset[7:2]: s_axi_rdata <= {16'h0000, ctrl_one_reg};
                ctrl_two_offset[7:2]: s_axi_rdata <= {16'h0000,
                                       ctrl_two_reg & ctrl_two_mask};
                status_offset[7:2]: s_axi_rdata <= {29'h00000000, tx_pend_reg,
                                       rx_full_reg, state_reg != st_idle};
                data_offset[7:2]: s_axi_rdata <= {24'h000000, rx_data_reg};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= resp_slverr;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************************
    // pin synchronisers
    // ****************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ss_meta_reg <= 1'b1;
            ss_sync_reg <= 1'b1;
            ss_prev_reg <= 1'b1;
            din_meta_reg <= 1'b0;
            din_sync_reg <= 1'b0;
        end else begin
            ss_meta_reg <= slave_select_pin_in;
            ss_sync_reg <= ss_meta_reg;
            ss_prev_reg <= ss_sync_reg;
            din_meta_reg <= serial_data_in;
            din_sync_reg <= din_meta_reg;
        end
    end

    // incoming pulse seen in the programmed polarity
    assign ss_active_in = ss_sync_reg == ctrl_two_reg[fpol_bit];
    assign ext_start = ext_sync
                       && ss_active_in && (ss_prev_reg != ss_sync_reg);

    // ****************************************************
    // bit clock
    // ****************************************************
    spi_clock_divider u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(state_reg != st_idle),
        .primary_prescale(ctrl_one_reg[primary_prescale_lsb +: 2]),
        .secondary_prescale(ctrl_one_reg[secondary_prescale_lsb +: 3]),
        .tick(tick)
    );

    // ****************************************************
    // transmit holding and receive buffering
    // ****************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_pend_reg <= 1'b0;
            tx_hold_reg <= 8'h00;
        end else if (data_write) begin
            // legacy mode: a write while busy overwrites the pending byte
            tx_pend_reg <= 1'b1;
            tx_hold_reg <= w_data_reg[7:0];
        end else if (load_shift) begin
            tx_pend_reg <= 1'b0;
        end
    end

    assign load_shift = tx_pend_reg && (state_reg == st_idle
        || (ctrl_two_reg[ben_bit] && state_reg == st_shift && tick
            && sclk_reg && bit_cnt_reg == 4'h7));

    // ****************************************************
    // shift engine
    // ****************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= st_idle;
            bit_cnt_reg <= 4'h0;
            sclk_reg <= 1'b0;
            shift_reg <= 8'h00;
            sync_active_reg <= 1'b0;
        end else begin
            case (state_reg)
                st_idle: begin
                    sclk_reg <= 1'b0;
                    bit_cnt_reg <= 4'h0;
                    if (load_shift) begin
                        shift_reg <= tx_hold_reg;
                        if (!framed) begin
                            state_reg <= st_shift;
                        end else if (ext_sync) begin
                            state_reg <= st_wait;
                        end else if (ctrl_two_reg[fedge_bit]) begin
                            sync_active_reg <= 1'b1;
                            state_reg <= st_shift;
                        end else begin
                            sync_active_reg <= 1'b1;
                            state_reg <= st_sync;
                        end
                    end
                end
                st_wait: begin
                    if (ext_start) begin
                        state_reg <= st_shift;
                    end
                end
                st_sync: begin
                    // one full bit clock ahead of the first bit
                    if (tick) begin
                        sclk_reg <= !sclk_reg;
                        if (sclk_reg) begin
                            sync_active_reg <= 1'b0;
                            state_reg <= st_shift;
                        end
                    end
                end
                st_shift: begin
                    if (tick) begin
                        sclk_reg <= !sclk_reg;
                        if (sclk_reg) begin
                            sync_active_reg <= 1'b0;
                            shift_reg <= {shift_reg[6:0], din_sync_reg};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            if (bit_cnt_reg == 4'(word_bits - 1)) begin
                                bit_cnt_reg <= 4'h0;
                                if (load_shift) begin
                                    shift_reg <= tx_hold_reg;
                                    sync_active_reg <= framed
                                        && !ext_sync;
                                end else begin
                                    state_reg <= st_idle;
                                end
                            end
                        end
                    end
                end
                default: state_reg <= st_idle;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_full_reg <= 1'b0;
            rx_data_reg <= 8'h00;
        end else if (state_reg == st_shift && tick && sclk_reg
                     && bit_cnt_reg == 4'(word_bits - 1)) begin
            rx_full_reg <= 1'b1;
            rx_data_reg <= {shift_reg[6:0], din_sync_reg};
        end else if (s_axi_arvalid && s_axi_arready
                     && s_axi_araddr[7:2] == data_offset[7:2]) begin
            rx_full_reg <= 1'b0;
        end
    end

    // ****************************************************
    // pins
    // ****************************************************
    // edge select ignored in framed mode, so idle-low clock only
    assign serial_clock = sclk_reg ^ (ctrl_one_reg[cke_bit] && !framed);
    assign serial_data_out = shift_reg[7];
    assign slave_select_pin_oe = framed && !ext_sync;
    assign slave_select_pin_out = sync_active_reg
                                  ? ctrl_two_reg[fpol_bit]
                                  : !ctrl_two_reg[fpol_bit];
endmodule : spi_frame_top

// *** design/spi_frame_pkg.sv ***
// constants for the serial clock prescale and framing block
package spi_frame_pkg;
    // ****************************************************
    // register map (byte addresses)
    // ****************************************************
    localparam logic [7:0] ctrl_one_offset = 8'h00;
    localparam logic [7:0] ctrl_two_offset = 8'h04;
    localparam logic [7:0] status_offset = 8'h08;
    localparam logic [7:0] data_offset = 8'h0c;
    // ****************************************************
    // field positions
    // ****************************************************
    localparam int primary_prescale_lsb = 0;
    localparam int secondary_prescale_lsb = 2;
    localparam int cke_bit = 8;
    localparam int master_bit = 5;
    localparam int enable_bit = 15;
    localparam int framed_mode_bit = 15;
    localparam int fsd_bit = 14;
    localparam int fpol_bit = 13;
    localparam int fedge_bit = 1;
    localparam int ben_bit = 0;
    localparam int busy_bit = 0;
    localparam int rx_full_bit = 1;
    // ****************************************************
    // reset values
    // ****************************************************
    localparam logic [15:0] ctrl_one_reset = 16'h0000;
    localparam logic [15:0] ctrl_two_reset = 16'h0000;
    localparam logic [15:0] ctrl_two_mask = 16'he003;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    localparam int word_bits = 8;
endpackage : spi_frame_pkg

// *** design/spi_clock_divider.sv ***
// bit clock tick generator from the two prescale fields
module spi_clock_divider
    import spi_frame_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic run,
    input wire logic [1:0] primary_prescale,
    input wire logic [2:0] secondary_prescale,
    // half-period tick
    output logic tick
);
    logic [9:0] count_reg;
    logic [9:0] limit;
    logic [6:0] prim_ratio;
    logic [3:0] sec_ratio;

    // ****************************************************
    // ratio decode
    // ****************************************************
    always_comb begin
        case (primary_prescale)
            2'h3: prim_ratio = 7'h01;
            2'h2: prim_ratio = 7'h04;
            2'h1: prim_ratio = 7'h10;
            default: prim_ratio = 7'h40;
        endcase
        sec_ratio = 4'h8 - {1'b0, secondary_prescale};
        // tick every ratio cycles, bit clock toggles per tick
        limit = 10'(prim_ratio) * 10'(sec_ratio) - 10'h001;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !run || count_reg >= limit) begin
            count_reg <= 10'h000;
        end else begin
            count_reg <= count_reg + 10'h001;
        end
    end

    assign tick = run && (count_reg >= limit);
endmodule : spi_clock_divider

// *** dv/spi_frame_assertions.sv ***
// port-level checker for the serial prescale and framing block
module spi_frame_checker
    import spi_frame_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial pins
    input wire logic serial_clock,
    input wire logic slave_select_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // control shadows
    // ********
    logic wr_hit, rd_hit;
    logic [15:0] one_reg, two_reg;
    logic [1:0] age_reg;
    logic [9:0] high_reg, half;
    // only writes whose address and data land together are tracked
    assign wr_hit = s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready;
    assign rd_hit = s_axi_arvalid && s_axi_arready && !wr_hit;
    assign half = (10'd1 << (3'd6 - {one_reg[1:0], 1'b0}))
        * (10'd8 - {7'd0, one_reg[4:2]});
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            one_reg <= 16'h0000;
            two_reg <= 16'h0000;
            age_reg <= 2'h3;
        end else if (wr_hit) begin
            if (s_axi_awaddr == ctrl_one_offset) one_reg <= s_axi_wdata[15:0];
            if (s_axi_awaddr == ctrl_two_offset) begin
                if (s_axi_wstrb[0]) two_reg[7:0] <= s_axi_wdata[7:0];
                if (s_axi_wstrb[1]) two_reg[15:8] <= s_axi_wdata[15:8];
            end
            age_reg <= 2'h0;
        end else if (age_reg != 2'h3) begin
            age_reg <= age_reg + 2'h1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || !serial_clock) high_reg <= 10'h000;
        else high_reg <= high_reg + 10'h001;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        wr_hit;
    endsequence
    sequence wr_answered;
        s_axi_bvalid ##[0:20] (s_axi_bvalid && s_axi_bready);
    endsequence
    write_resp_a: assert property (wr_taken |-> ##2 wr_answered)
        else $error("write answer missing");
    bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid) else $error("write answer repeated");
    read_resp_a: assert property (rd_hit |=> s_axi_rvalid)
        else $error("read answer late");
    rvalid_drop_a: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid) else $error("read answer repeated");
    two_read_a: assert property (
        rd_hit && s_axi_araddr == ctrl_two_offset |=>
        s_axi_rdata == {16'h0000, two_reg & ctrl_two_mask})
        else $error("control two readback wrong");
    unmapped_a: assert property (rd_hit && s_axi_araddr[7:2] > data_offset[7:2]
        |=> s_axi_rresp == resp_slverr && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    half_period_a: assert property (
        $fell(serial_clock) |-> high_reg == half)
        else $error("bit clock high time wrong");
    sync_dir_a: assert property (
        age_reg == 2'h3 |-> slave_select_pin_oe == (two_reg[framed_mode_bit]
        && !two_reg[fsd_bit])) else $error("sync pin direction wrong");
endmodule : spi_frame_checker

bind spi_frame_top spi_frame_checker u_checker (.*);

// *** dv/spi_peer_model.sv ***
// behavioural serial peer on the far side of the pins
module spi_peer_model
(
    // clock
    input wire logic aclk,
    // serial pins
    input wire logic serial_clock,
    input wire logic serial_data_out,
    output logic serial_data_in,
    output logic slave_select_pin_in,
    // capture
    output logic [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] tx_reg;
    int bit_cnt;
    initial begin
        serial_data_in = 1'b0;
        slave_select_pin_in = 1'b0;
        rx_byte = 8'h00;
        tx_reg = 8'h00;
        bit_cnt = 8;
    end
    task automatic load(input logic [7:0] b);
        tx_reg <= b;
        bit_cnt <= 0;
        serial_data_in <= b[7];
    endtask : load
    task automatic sync_pulse(input logic pol);
        @(posedge aclk);
        slave_select_pin_in <= pol;
        repeat (8) @(posedge aclk);
        slave_select_pin_in <= ~pol;
    endtask : sync_pulse
    always @(posedge serial_clock) begin
        rx_byte <= {rx_byte[6:0], serial_data_out};
        bit_cnt <= bit_cnt + 1;
    end
    // after the last bit the line flips, so a stale bit never passes
    always @(negedge serial_clock) begin
        if (bit_cnt < 8) serial_data_in <= tx_reg[7 - bit_cnt];
        else serial_data_in <= ~serial_data_in;
    end
endmodule : spi_peer_model

// *** dv/testbench.sv ***
// self-checking bench for the serial prescale and framing block
module testbench
    import spi_frame_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn;
    logic [7:0] s_axi_awaddr, s_axi_araddr, rx_byte, tb;
    logic [31:0] s_axi_wdata, s_axi_rdata, got;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp, pp;
    logic [2:0] sp;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, serial_clock, serial_data_out;
    logic serial_data_in, slave_select_pin_in;
    logic slave_select_pin_out, slave_select_pin_oe;
    int n_fail, num_checks, c, h;
    spi_frame_top u_spi_frame_top (.*);
    spi_peer_model u_spi_peer_model (.*);
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // ********
    // tasks
    // ********
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test
    task automatic tmo();
        n_fail++;
        $display("[ERR] %0t wait ran out", $time);
        stop_test();
    endtask : tmo
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic chk_resp(input logic [1:0] e);
        chk({30'h0, resp}, {30'h0, e});
    endtask : chk_resp
    task automatic chk_bit(input logic g, input logic e);
        chk({31'h0, g}, {31'h0, e});
    endtask : chk_bit
    task automatic axi_wr(input logic [7:0] a, input logic [15:0] d);
        logic aw, w, b;
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) break;
        end
        if (n == 50) tmo();
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        logic ar, r;
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge aclk);
            ar = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid;
            got = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (r) break;
        end
        if (n == 50) tmo();
    endtask : axi_rd
    task automatic wait_clk(input logic lvl, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (serial_clock !== lvl && n < lim);
        if (serial_clock !== lvl) tmo();
    endtask : wait_clk
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            axi_rd(status_offset);
            n++;
        end while (got[busy_bit] !== 1'b0 && n < 2000);
        if (got[busy_bit] !== 1'b0) tmo();
    endtask : wait_idle
    // ********
    // main sequence
    // ********
    initial begin
        n_fail = 0;
        num_checks = 0;
        aresetn = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_arvalid = 1'b0;
        // answers are always accepted at once
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk_bit(slave_select_pin_oe, 1'b0);
        axi_rd(ctrl_two_offset);
        chk(got, 32'h0);
        axi_wr(ctrl_two_offset, 16'hffff);
        axi_rd(ctrl_two_offset);
        chk(got, 32'he003);
        axi_wr(ctrl_two_offset, 16'h5ffe);
        axi_rd(ctrl_two_offset);
        chk(got, 32'h4002);
        // high byte only: the low byte must keep its value
        s_axi_wstrb <= 4'h2;
        axi_wr(ctrl_two_offset, 16'h2001);
        s_axi_wstrb <= 4'hf;
        axi_rd(ctrl_two_offset);
        chk(got, 32'h2002);
        axi_wr(ctrl_two_offset, 16'h0000);
        axi_rd(8'h10);
        chk_resp(resp_slverr);
        chk(got, 32'h0);
        axi_wr(8'h10, 16'h1234);
        chk_resp(resp_slverr);
        $display("test registers done");
        for (int i = 0; i < 12; i++) begin
            pp = (i < 8) ? 2'h3 : 2'(i - 8);
            sp = (i < 8) ? 3'(i) : 3'h7;
            h = (1 << (6 - 2 * pp)) * (8 - sp);
            tb = 8'h5a ^ 8'(i * 37);
            axi_wr(ctrl_one_offset, {1'b1, 9'h0, 1'b1, sp, pp});
            u_spi_peer_model.load(~tb);
            axi_wr(data_offset, {8'h00, tb});
            wait_clk(1'b1, 2000);
            c = 0;
            do begin
                @(negedge aclk);
                c++;
            end while (serial_clock === 1'b1 && c < 1000);
            chk(32'(c), 32'(h));
            wait_idle();
            chk({24'h0, rx_byte}, {24'h0, tb});
            // the fastest rates outrun the input synchroniser
            if (h >= 4) begin
                axi_rd(data_offset);
                chk(got & 32'hff, {24'h0, ~tb});
            end
        end
        $display("test prescale done");
        axi_wr(ctrl_one_offset, 16'h803a);
        for (int k = 0; k < 4; k++) begin
            axi_wr(ctrl_two_offset, {2'b10, k[0], 11'h0, k[1], 1'b0});
            @(negedge aclk);
            chk_bit(slave_select_pin_oe, 1'b1);
            axi_wr(data_offset, 16'h00c3);
            for (c = 0; c < 100 && slave_select_pin_out !== k[0]; c++) begin
                @(negedge aclk);
            end
            chk_bit(slave_select_pin_out, k[0]);
            wait_clk(1'b1, 200);
            chk_bit(slave_select_pin_out, k[0]);
            wait_clk(1'b0, 200);
            // edge clear: the first clock belongs to the sync, skip it
            if (!k[1]) wait_clk(1'b1, 200);
            chk_bit(slave_select_pin_out, ~k[0]);
            wait_idle();
        end
        $display("test framed master done");
        axi_wr(ctrl_two_offset, 16'h0001);
        axi_wr(data_offset, 16'h0011);
        axi_wr(data_offset, 16'h0022);
        for (int j = 0; j < 8; j++) begin
            wait_clk(1'b1, 200);
            wait_clk(1'b0, 200);
        end
        // back to back words keep a plain half period low between them
        c = 0;
        do begin
            @(negedge aclk);
            c++;
        end while (serial_clock === 1'b0 && c < 100);
        chk(32'(c), 32'd8);
        wait_idle();
        chk({24'h0, rx_byte}, 32'h22);
        $display("test enhanced buffer done");
        axi_wr(ctrl_two_offset, 16'he000);
        @(negedge aclk);
        chk_bit(slave_select_pin_oe, 1'b0);
        axi_wr(data_offset, 16'h003c);
        for (c = 0; c < 60 && serial_clock !== 1'b1; c++) @(negedge aclk);
        chk(32'(c), 32'd60);
        u_spi_peer_model.sync_pulse(1'b1);
        wait_idle();
        chk({24'h0, rx_byte}, 32'h3c);
        $display("test framed slave done");
        stop_test();
    end
endmodule : testbench
